// [pkg/fmasc_defines.svh]
// Constants for the fused multiply-add result selection block.
`ifndef FMASC_DEFINES_SVH
`define FMASC_DEFINES_SVH
`define FMASC_LANES 8
`define FMASC_NARROW_LANES 4
`define FMASC_FLAG_INVALID 0
`define FMASC_FLAG_DENORMAL 1
`define FMASC_FLAG_OVERFLOW 2
`define FMASC_FLAG_UNDERFLOW 3
`define FMASC_FLAG_INEXACT 4
`define FMASC_OP_NEG_ADDEND 0
`define FMASC_OP_NEG_PRODUCT 1
`define FMASC_ID_LEAF_FEATURES 32'h0000_0001
`define FMASC_FEAT_FMA_BIT 12
`define FMASC_FEAT_SAVE_EN_BIT 27
`define FMASC_FEAT_VECTOR_BIT 28
`define FMASC_DEFAULT_NAN 32'hffc0_0000
`define FMASC_QUIET_BIT 32'h0040_0000
`define FMASC_INF_MAG 31'h7f80_0000
`define FMASC_MAX_MAG 31'h7f7f_ffff
`define FMASC_PROD_LSB_BIAS 12'sh146
`define FMASC_ADDEND_OFFSET 12'sh0b0
`define FMASC_ADDEND_CAP 12'sh032
`define FMASC_EXP_BIAS 12'sh07f
`define FMASC_EXP_MAX 12'sh0ff
`endif

// [pkg/fmasc_pkg.sv]
// Types shared by the fused multiply-add block.
package fmasc_pkg;
    typedef enum logic [1:0] {
        FMASC_RM_NEAREST = 2'h0,
        FMASC_RM_DOWN = 2'h1,
        FMASC_RM_UP = 2'h2,
        FMASC_RM_ZERO = 2'h3
    } fmasc_rmode_t;
    typedef struct packed {
        logic valid;
        logic [1:0] op;
        fmasc_rmode_t rmode;
        logic wide;
        logic [4:0] mask;
        logic [255:0] x;
        logic [255:0] y;
        logic [255:0] z;
    } fmasc_req_t;
    typedef struct packed {
        logic valid;
        logic wr_en;
        logic fault;
        logic [4:0] flags;
        logic [255:0] data;
    } fmasc_rsp_t;
endpackage : fmasc_pkg

// [rtl/fmasc_top.sv]
// Fused multiply-add datapath with special cases, rounding and exception gating.
`timescale 1ns/1ns
`include "fmasc_defines.svh"

module fmasc_lane (
    input wire logic [31:0] x,
    input wire logic [31:0] y,
    input wire logic [31:0] z,
    input wire logic [1:0] op,
    input wire fmasc_pkg::fmasc_rmode_t rmode,
    output logic [31:0] res,
    output logic [4:0] flags
);
    import fmasc_pkg::*;

    function automatic logic [75:0] shr_sticky(input logic [75:0] v, input logic [11:0] n);
        logic [75:0] lost;
        lost = (n > 12'd75) ? v : (v & ~({76{1'b1}} << n));
        return ((n > 12'd75) ? 76'h0 : (v >> n)) | {75'h0, |lost};
    endfunction : shr_sticky

    logic sp, szn, x_nan, y_nan, z_nan, any_snan, x_inf, y_inf, z_inf, p_inf, p_zero, z_zero;
    logic eff_sub, rs, inc, inexact, tiny;
    logic [23:0] mx, my, mz, mant, mant_f;
    logic [24:0] mr;
    logic [47:0] prod;
    logic [75:0] pa, za, sum, norm;
    logic [6:0] k;
    logic signed [11:0] ex_e, ey_e, ez_e, lbase, s_amt, e_val, exp_out;

    assign x_nan = (x[30:23] == 8'hff) && (x[22:0] != 23'h0);
    assign y_nan = (y[30:23] == 8'hff) && (y[22:0] != 23'h0);
    assign z_nan = (z[30:23] == 8'hff) && (z[22:0] != 23'h0);
    assign any_snan = (x_nan && !x[22]) || (y_nan && !y[22]) || (z_nan && !z[22]);
    assign x_inf = x[30:0] == `FMASC_INF_MAG;
    assign y_inf = y[30:0] == `FMASC_INF_MAG;
    assign z_inf = z[30:0] == `FMASC_INF_MAG;
    assign z_zero = z[30:0] == 31'h0;
    assign p_inf = x_inf || y_inf;
    assign p_zero = (x[30:0] == 31'h0) || (y[30:0] == 31'h0);
    assign sp = x[31] ^ y[31] ^ op[`FMASC_OP_NEG_PRODUCT];
    assign szn = z[31] ^ op[`FMASC_OP_NEG_ADDEND];
    assign mx = {x[30:23] != 8'h0, x[22:0]};
    assign my = {y[30:23] != 8'h0, y[22:0]};
    assign mz = {z[30:23] != 8'h0, z[22:0]};
    assign ex_e = {4'h0, (x[30:23] == 8'h0) ? 8'h01 : x[30:23]};
    assign ey_e = {4'h0, (y[30:23] == 8'h0) ? 8'h01 : y[30:23]};
    assign ez_e = {4'h0, (z[30:23] == 8'h0) ? 8'h01 : z[30:23]};
    assign prod = mx * my;

    // ------------------------------------------------------------
    // Alignment, exact sum and single rounding
    // ------------------------------------------------------------
    // exact sum, one rounding
    always_comb begin
        s_amt = ez_e - ex_e - ey_e + `FMASC_ADDEND_OFFSET;
        lbase = ex_e + ey_e - `FMASC_PROD_LSB_BIAS;
        pa = {2'h0, prod, 26'h0};
        za = {52'h0, mz};
        if (s_amt > `FMASC_ADDEND_CAP) begin
            pa = shr_sticky(pa, s_amt - `FMASC_ADDEND_CAP);
            za = za << `FMASC_ADDEND_CAP;
            lbase = lbase + s_amt - `FMASC_ADDEND_CAP;
        end else if (s_amt < 12'sh000) begin
            za = shr_sticky(za, 12'sh000 - s_amt);
        end else begin
            za = za << s_amt;
        end
        eff_sub = sp ^ szn;
        rs = (pa >= za) ? sp : szn;
        if (eff_sub) begin
            sum = (pa >= za) ? pa - za : za - pa;
        end else begin
            sum = pa + za;
        end
        k = 7'h0;
        for (int i = 0; i < 76; i++) begin
            if (sum[i]) begin
                k = 7'(i);
            end
        end
        e_val = lbase + $signed({5'h0, k}) + `FMASC_EXP_BIAS;
        tiny = e_val < 12'sh001;
        norm = sum << (7'd75 - k);
        if (tiny) begin
            norm = shr_sticky(norm, 12'sh001 - e_val);
            e_val = 12'sh001;
        end
        mant = norm[75:52];
        inexact = norm[51] || (|norm[50:0]);
        case (rmode)
            FMASC_RM_NEAREST: inc = norm[51] && ((|norm[50:0]) || mant[0]);
            FMASC_RM_DOWN: inc = rs && inexact;
            FMASC_RM_UP: inc = !rs && inexact;
            default: inc = 1'b0;
        endcase
        mr = {1'b0, mant} + {24'h0, inc};
        mant_f = mr[24] ? mr[24:1] : mr[23:0];
        exp_out = mr[24] ? e_val + 12'sh001 : e_val;
        exp_out = mant_f[23] ? exp_out : 12'sh000;
        flags = 5'h0;
        flags[`FMASC_FLAG_DENORMAL] = ((x[30:23] == 8'h0) && (x[22:0] != 23'h0))
            || ((y[30:23] == 8'h0) && (y[22:0] != 23'h0))
            || ((z[30:23] == 8'h0) && (z[22:0] != 23'h0));
        if (x_nan || y_nan || z_nan) begin
            flags[`FMASC_FLAG_INVALID] = any_snan;
            res = x_nan ? x : (y_nan ? y : z);
            res = res | `FMASC_QUIET_BIT;
        end else if ((p_inf && p_zero) || (p_inf && z_inf && eff_sub)) begin
            flags[`FMASC_FLAG_INVALID] = 1'b1;
            res = `FMASC_DEFAULT_NAN;
        end else if (p_inf) begin
            res = {sp, `FMASC_INF_MAG};
        end else if (z_inf) begin
            res = {szn, `FMASC_INF_MAG};
        end else if (p_zero && z_zero) begin
            res = {eff_sub ? (rmode == FMASC_RM_DOWN) : sp, 31'h0};
        end else if (p_zero) begin
            res = {szn, z[30:0]};
        end else if (sum == 76'h0) begin
            res = {rmode == FMASC_RM_DOWN, 31'h0};
        end else if (exp_out >= `FMASC_EXP_MAX) begin
            flags[`FMASC_FLAG_OVERFLOW] = 1'b1;
            flags[`FMASC_FLAG_INEXACT] = 1'b1;
            if ((rmode == FMASC_RM_ZERO) || (rmode == FMASC_RM_DOWN && !rs)
                || (rmode == FMASC_RM_UP && rs)) begin
                res = {rs, `FMASC_MAX_MAG};
            end else begin
                res = {rs, `FMASC_INF_MAG};
            end
        end else begin
            flags[`FMASC_FLAG_INEXACT] = inexact;
            flags[`FMASC_FLAG_UNDERFLOW] = tiny && inexact;
            res = {rs, exp_out[7:0], mant_f[22:0]};
        end
    end
endmodule : fmasc_lane

module fmasc_top (
    input wire logic clock,
    input wire logic rstn,
    input wire fmasc_pkg::fmasc_req_t req,
    output fmasc_pkg::fmasc_rsp_t rsp,
    input wire logic id_req,
    input wire logic [31:0] id_leaf,
    input wire logic os_save_en,
    output logic id_valid,
    output logic [31:0] id_word
);
    import fmasc_pkg::*;

    logic rst_meta_reg, rst_sync_reg;
    logic [31:0] lane_res [`FMASC_LANES];
    logic [4:0] lane_flags [`FMASC_LANES];
    fmasc_rsp_t rsp_reg, rsp_next;
    logic id_valid_reg, id_valid_next;
    logic [31:0] id_word_reg, id_word_next;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Lanes
    // ------------------------------------------------------------
    for (genvar i = 0; i < `FMASC_LANES; i++) begin : g_lane
        fmasc_lane u_lane (
            .x(req.x[32*i +: 32]),
            .y(req.y[32*i +: 32]),
            .z(req.z[32*i +: 32]),
            .op(req.op),
            .rmode(req.rmode),
            .res(lane_res[i]),
            .flags(lane_flags[i])
        );
    end

    always_comb begin
        rsp_next = '0;
        rsp_next.valid = req.valid;
        for (int i = 0; i < `FMASC_LANES; i++) begin
            if (i < `FMASC_NARROW_LANES || req.wide) begin
                rsp_next.data[32*i +: 32] = lane_res[i];
                rsp_next.flags = rsp_next.flags | lane_flags[i];
            end
        end
        rsp_next.fault = req.valid && (|(rsp_next.flags & ~req.mask));
        rsp_next.wr_en = req.valid && !rsp_next.fault;
        if (!req.valid) begin
            rsp_next.flags = 5'h0;
            rsp_next.data = '0;
        end
    end

    always_comb begin
        id_valid_next = id_req;
        id_word_next = 32'h0000_0000;
        if (id_req && id_leaf == `FMASC_ID_LEAF_FEATURES) begin
            id_word_next[`FMASC_FEAT_FMA_BIT] = 1'b1;
            id_word_next[`FMASC_FEAT_VECTOR_BIT] = 1'b1;
            id_word_next[`FMASC_FEAT_SAVE_EN_BIT] = os_save_en;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rsp_reg <= '0;
            id_valid_reg <= 1'b0;
            id_word_reg <= 32'h0000_0000;
        end else begin
            rsp_reg <= rsp_next;
            id_valid_reg <= id_valid_next;
            id_word_reg <= id_word_next;
        end
    end

    assign rsp = rsp_reg;
    assign id_valid = id_valid_reg;
    assign id_word = id_word_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_reg);

    a_fault_no_write: assert property (rsp.valid |-> rsp.fault != rsp.wr_en
        && rsp.fault == (|(rsp.flags & ~$past(req.mask))))
        else $error("destination write does not follow unmasked exceptions");
    a_inexact_fault: assert property (req.valid && !req.mask[4]
        && req.x[31:0] == 32'h3f80_0001 && req.y[31:0] == 32'h3f80_0001
        && req.z[31:0] == 32'h0000_0000 |=> rsp.fault && !rsp.wr_en)
        else $error("unmasked inexact did not fault");
    a_feature_bit: assert property (id_req && id_leaf == 32'h0000_0001
        |=> id_valid && id_word[12])
        else $error("feature bit missing");
    a_zero_sign_down: assert property (req.valid && req.rmode == FMASC_RM_DOWN
        && req.op == 2'h0 && req.x[31:0] == 32'h0000_0000 && req.y[31:0] == 32'h3f80_0000
        && req.z[31:0] == 32'h8000_0000 |=> rsp.data[31:0] == 32'h8000_0000)
        else $error("zero sum sign wrong when rounding down");
    a_product_sign: assert property (req.valid && req.op == 2'h0
        && req.x[31:0] == 32'h8000_0000 && req.y[31:0] == 32'h3f80_0000
        && req.z[31:0] == 32'h8000_0000 |=> rsp.data[31:0] == 32'h8000_0000)
        else $error("zero product sign wrong");
    a_exact_sum: assert property (req.valid && req.rmode == FMASC_RM_NEAREST
        && req.op == 2'h0 && req.x[31:0] == 32'h3f80_0000 && req.y[31:0] == 32'h4000_0000
        && req.z[31:0] == 32'h3f80_0000 |=> rsp.data[31:0] == 32'h4040_0000)
        else $error("finite sum wrong");
    a_cancel_zero: assert property (req.valid && req.rmode != FMASC_RM_DOWN
        && req.op == 2'h1 && req.x[31:0] == 32'h3f80_0000 && req.y[31:0] == 32'h3f80_0000
        && req.z[31:0] == 32'h3f80_0000 |=> rsp.data[31:0] == 32'h0000_0000)
        else $error("cancellation zero sign wrong");
    a_narrow_upper: assert property (req.valid && !req.wide
        |=> rsp.valid && rsp.data[255:128] == 128'h0)
        else $error("narrow operation wrote upper lanes");
    a_inf_addend: assert property (req.valid && req.op == 2'h1
        && req.x[31:0] == 32'h3f80_0000 && req.y[31:0] == 32'h3f80_0000
        && req.z[31:0] == 32'h7f80_0000 |=> rsp.data[31:0] == 32'hff80_0000
        && !rsp.flags[0])
        else $error("infinite addend result wrong");
    a_zero_prod_addend: assert property (req.valid && req.op == 2'h1
        && req.x[31:0] == 32'h0000_0000 && req.z[31:0] == 32'h3fc0_0000
        && req.y[30:23] != 8'hff |=> rsp.data[31:0] == 32'hbfc0_0000)
        else $error("zero product did not return addend");
endmodule : fmasc_top

// [test/fmasc_pipe_model.sv]
// Execution pipeline model: destination register and feature detection check.
`timescale 1ns/1ns

module fmasc_pipe_model #(
    parameter logic [31:0] extended_control_reg_zero = 32'h0000_0006
) (
    input wire logic clock,
    input wire logic rstn,
    input wire fmasc_pkg::fmasc_rsp_t rsp,
    input wire logic id_valid,
    input wire logic [31:0] id_word,
    output logic [255:0] dest,
    output logic fma_ok
);
    import fmasc_pkg::*;

    logic [255:0] dest_reg;
    logic [255:0] dest_next;

    // ----------------------------------------
    // Destination register
    // ----------------------------------------
    // gated wide write
    always_comb begin
        dest_next = dest_reg;
        if (rsp.valid && rsp.wr_en) begin
            dest_next = rsp.data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dest_reg <= '0;
        end else begin
            dest_reg <= dest_next;
        end
    end

    assign dest = dest_reg;

    // ----------------------------------------
    // Software detection
    // ----------------------------------------
    // feature and state check
    always_comb begin
        fma_ok = id_valid && ((id_word & 32'h1800_1000) == 32'h1800_1000)
            && ((extended_control_reg_zero & 32'h0000_0006) == 32'h0000_0006);
    end
endmodule : fmasc_pipe_model

// [test/test_fmasc_top.sv]
// Self-checking testbench for the fused multiply-add block.
`timescale 1ns/1ns

module test_fmasc_top;
    import fmasc_pkg::*;

    typedef struct packed {
        logic [1:0] op;
        logic [1:0] rm;
        logic wide;
        logic [4:0] mask;
        logic [31:0] x, y, z, res;
        logic [4:0] flags;
        logic fault;
    } fmasc_row_t;

    localparam logic [31:0] PZ = 32'h0000_0000, NZ = 32'h8000_0000, P1 = 32'h3f80_0000;
    localparam logic [31:0] M1 = 32'hbf80_0000, P2 = 32'h4000_0000, P3 = 32'h4040_0000;
    localparam logic [31:0] M3 = 32'hc040_0000, PI = 32'h7f80_0000, NI = 32'hff80_0000;
    localparam logic [31:0] E1 = 32'h3f80_0001, E2 = 32'h3f80_0002, MX = 32'h7f7f_ffff;

    // ----------------------------------------
    // Ordinary, special-value and exception fault cases
    // ----------------------------------------
    localparam fmasc_row_t rows [31] = '{
        '{2'h0, 2'h0, 1'h1, 5'h1f, PZ, M1, NZ, NZ, 5'h00, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h1f, PZ, M1, PZ, PZ, 5'h00, 1'h0},
        '{2'h0, 2'h1, 1'h0, 5'h1f, PZ, M1, PZ, NZ, 5'h00, 1'h0},
        '{2'h3, 2'h2, 1'h1, 5'h1f, PZ, P1, PZ, NZ, 5'h00, 1'h0},
        '{2'h1, 2'h3, 1'h1, 5'h1f, PZ, P1, PZ, PZ, 5'h00, 1'h0},
        '{2'h1, 2'h0, 1'h1, 5'h1f, P1, P2, P2, PZ, 5'h00, 1'h0},
        '{2'h1, 2'h1, 1'h0, 5'h1f, P1, P2, P2, NZ, 5'h00, 1'h0},
        '{2'h2, 2'h2, 1'h1, 5'h1f, P1, P2, P2, PZ, 5'h00, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h1f, P3, P3, P1, 32'h4120_0000, 5'h00, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h1f, E1, E1, 32'hbf80_0002, 32'h2880_0000, 5'h00, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h1f, E1, E1, PZ, E2, 5'h10, 1'h0},
        '{2'h0, 2'h2, 1'h1, 5'h1f, E1, E1, PZ, 32'h3f80_0003, 5'h10, 1'h0},
        '{2'h0, 2'h1, 1'h0, 5'h1f, E1, E1, PZ, E2, 5'h10, 1'h0},
        '{2'h0, 2'h3, 1'h1, 5'h1f, E1, E1, PZ, E2, 5'h10, 1'h0},
        '{2'h1, 2'h0, 1'h1, 5'h1f, PZ, P3, PI, NI, 5'h00, 1'h0},
        '{2'h2, 2'h0, 1'h1, 5'h1f, P1, P3, NI, NI, 5'h00, 1'h0},
        '{2'h1, 2'h0, 1'h0, 5'h1f, P1, P3, NI, PI, 5'h00, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h1f, PZ, P1, P3, P3, 5'h00, 1'h0},
        '{2'h3, 2'h0, 1'h0, 5'h1f, PZ, P1, P3, M3, 5'h00, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h0f, E1, E1, PZ, E2, 5'h10, 1'h1},
        '{2'h0, 2'h0, 1'h1, 5'h1b, MX, P2, PZ, PI, 5'h14, 1'h1},
        '{2'h0, 2'h0, 1'h1, 5'h1f, MX, P2, PZ, PI, 5'h14, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h1e, PI, PZ, PZ, 32'hffc0_0000, 5'h01, 1'h1},
        '{2'h0, 2'h0, 1'h1, 5'h1d, 32'h0000_0001, P1, PZ, 32'h0000_0001, 5'h02, 1'h1},
        '{2'h0, 2'h1, 1'h1, 5'h1f, PZ, P1, NZ, NZ, 5'h00, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h1f, NZ, P1, NZ, NZ, 5'h00, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h1f, P1, P2, P1, P3, 5'h00, 1'h0},
        '{2'h1, 2'h0, 1'h1, 5'h1f, P1, P1, P1, PZ, 5'h00, 1'h0},
        '{2'h1, 2'h0, 1'h1, 5'h1f, P1, P1, PI, NI, 5'h00, 1'h0},
        '{2'h1, 2'h0, 1'h1, 5'h1f, PZ, P1, 32'h3fc0_0000, 32'hbfc0_0000, 5'h00, 1'h0},
        '{2'h0, 2'h0, 1'h1, 5'h17, 32'h0080_0000, 32'h3f00_0001, PZ, 32'h0040_0000, 5'h18, 1'h1}
    };

    logic clock = 1'b0;
    logic rstn = 1'b0;
    fmasc_req_t req = '0;
    fmasc_rsp_t rsp;
    logic id_req = 1'b0;
    logic [31:0] id_leaf = 32'h0000_0000;
    logic os_save_en = 1'b1;
    logic id_valid;
    logic [31:0] id_word;
    logic fma_ok;
    logic fma_ok_no_state;
    logic [255:0] dest;
    logic [255:0] exp_dest = '0;
    int err_total = 0;
    int num_checks = 0;

    always #25 clock = ~clock;

    fmasc_top u_dut (.clock(clock), .rstn(rstn), .req(req), .rsp(rsp), .id_req(id_req),
        .id_leaf(id_leaf), .os_save_en(os_save_en), .id_valid(id_valid), .id_word(id_word));

    fmasc_pipe_model u_model (.clock(clock), .rstn(rstn), .rsp(rsp), .id_valid(id_valid),
        .id_word(id_word), .dest(dest), .fma_ok(fma_ok));

    // Software whose control register lacks the wide state must refuse the feature.
    fmasc_pipe_model #(.extended_control_reg_zero(32'h0000_0002)) u_model_no_state (
        .clock(clock), .rstn(rstn), .rsp(rsp), .id_valid(id_valid), .id_word(id_word),
        .dest(), .fma_ok(fma_ok_no_state));

    // ----------------------------------------
    // Compare and drive tasks
    // ----------------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_vec(input string what, input logic [255:0] exp, input logic [255:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_vec

    // Narrow requests carry invalid operands in the upper lanes, which must stay silent.
    task automatic drive(input fmasc_row_t r);
        req.valid = 1'b1;
        req.op = r.op;
        req.rmode = fmasc_rmode_t'(r.rm);
        req.wide = r.wide;
        req.mask = r.mask;
        req.x = r.wide ? {8{r.x}} : {{4{PI}}, {4{r.x}}};
        req.y = r.wide ? {8{r.y}} : {{4{PZ}}, {4{r.y}}};
        req.z = {8{r.z}};
    endtask : drive

    task automatic check_rsp(input fmasc_row_t r);
        logic [255:0] e;
        e = r.wide ? {8{r.res}} : {128'h0, {4{r.res}}};
        chk_bit("rsp_valid", 1'b1, rsp.valid);
        chk_vec("rsp_data", e, rsp.data);
        chk_vec("rsp_flags", 256'(r.flags), 256'(rsp.flags));
        chk_bit("rsp_wr_en", !r.fault, rsp.wr_en);
        chk_bit("rsp_fault", r.fault, rsp.fault);
        if (!r.fault) begin
            exp_dest = e;
        end
    endtask : check_rsp

    task automatic idle_check();
        chk_bit("rsp_idle", 1'b0, rsp.valid);
        chk_vec("rsp_idle_data", '0, rsp.data);
        chk_vec("dest", exp_dest, dest);
    endtask : idle_check

    task automatic run_row(input fmasc_row_t r);
        @(posedge clock);
        #1;
        drive(r);
        @(posedge clock);
        #1;
        req.valid = 1'b0;
        check_rsp(r);
        @(posedge clock);
        #1;
        idle_check();
    endtask : run_row

    task automatic run_id(input logic [31:0] leaf, input logic save, input logic [31:0] exp);
        @(posedge clock);
        #1;
        id_req = 1'b1;
        id_leaf = leaf;
        os_save_en = save;
        @(posedge clock);
        #1;
        id_req = 1'b0;
        chk_bit("id_valid", 1'b1, id_valid);
        chk_vec("id_word", 256'(exp), 256'(id_word));
        chk_bit("fma_ok", exp == 32'h1800_1000, fma_ok);
        chk_bit("fma_ok_no_state", 1'b0, fma_ok_no_state);
    endtask : run_id

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        #1;
        chk_bit("reset_valid", 1'b0, rsp.valid);
        chk_bit("reset_id_valid", 1'b0, id_valid);
        rstn = 1'b1;
        repeat (3) @(posedge clock);
        $display("test reset done");
        for (int i = 0; i < 31; i++) begin
            run_row(rows[i]);
        end
        $display("test table done");
        run_id(32'h0000_0001, 1'b1, 32'h1800_1000);
        run_id(32'h0000_0001, 1'b0, 32'h1000_1000);
        run_id(32'h0000_0002, 1'b1, 32'h0000_0000);
        $display("test identification done");
        @(posedge clock);
        #1;
        drive(rows[10]);
        @(posedge clock);
        #1;
        drive(rows[19]);
        check_rsp(rows[10]);
        @(posedge clock);
        #1;
        req.valid = 1'b0;
        check_rsp(rows[19]);
        @(posedge clock);
        #1;
        idle_check();
        $display("test back to back done");
        @(posedge clock);
        #1;
        drive(rows[8]);
        rstn = 1'b0;
        exp_dest = '0;
        @(posedge clock);
        #1;
        req.valid = 1'b0;
        chk_bit("valid_after_reset", 1'b0, rsp.valid);
        chk_vec("dest_after_reset", '0, dest);
        repeat (2) @(posedge clock);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge clock);
        run_row(rows[8]);
        $display("test mid reset done");
        conclude();
    end

    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        $display("CHECK FAILED watchdog expected finished seen running");
        conclude();
    end
endmodule : test_fmasc_top
